// [design/eeld_blinker.v]
// free running fast and slow blink square waves for the lamps
`timescale 1ns/1ps
`default_nettype none
`include "eeld_defines.vh"
module eeld_blinker #(
    parameter FAST_HALF = `EELD_FAST_HALF_CYC,
    parameter SLOW_HALF = `EELD_SLOW_HALF_CYC
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // blink levels
    output reg blink_fast,
    output reg blink_slow
);
    reg [31:0] fast_cnt;
    reg [31:0] slow_cnt;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            fast_cnt <= 32'h0;
            slow_cnt <= 32'h0;
            blink_fast <= 1'b0;
            blink_slow <= 1'b0;
        end else begin
            if (fast_cnt >= FAST_HALF - 1) begin
                fast_cnt <= 32'h0;
                blink_fast <= ~blink_fast;
            end else begin
                fast_cnt <= fast_cnt + 32'h1;
            end
            if (slow_cnt >= SLOW_HALF - 1) begin
                slow_cnt <= 32'h0;
                blink_slow <= ~blink_slow;
            end else begin
                slow_cnt <= slow_cnt + 32'h1;
            end
        end
    end
endmodule // eeld_blinker
`default_nettype wire

// [design/eeld_config_loader.v]
// configuration word loader with status lamp decoder
//
// Summary of operation
// - chip word bit 0 set turns expansion rom off
// - chip word bits 4..6 give rate bits
// - chip word bit 8 selects forced setup mode
// - chip word bit 15 loads wake lan enable
// - subsystem ident word loads ident register
// - lower base word bit 0 is power saving
// - forced mode: base bits 15..8 from lower word
// - forced mode: base bits 31..16 from upper word
// - led word bits 1:0 pick mode, default 1
// - mode 1: rate lamps lit at matching link
// - mode 1: duplex lamp full, blink on collision
// - mode 0: hundred/ten lamps encode link rate
// - mode 0: thousand lamp lit on any link
// - mode 2: ten lamp dark at 10, slow blink 100
// - auto initialization loads words into registers
// - words fetched from offsets 1 to 6
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "eeld_defines.vh"
module eeld_config_loader #(
    parameter FAST_HALF = `EELD_FAST_HALF_CYC,
    parameter SLOW_HALF = `EELD_SLOW_HALF_CYC
) (
    // clock and reset
    input wire CORE_CLK,
    input wire RESET,
    // register port
    input wire [7:0] ADDR,
    input wire [31:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [31:0] RDATA,
    // word read port towards the serial store controller
    output reg EE_REQ,
    output reg [5:0] EE_ADDR,
    input wire [15:0] EE_DATA,
    input wire EE_VALID,
    // phy status pins, asynchronous
    input wire LINK_UP,
    input wire [1:0] LINK_RATE,
    input wire FULL_DUPLEX,
    input wire COLLISION,
    input wire RX_ACTIVE,
    input wire TX_ACTIVE,
    // loaded configuration
    output reg EXPANSION_ROM_OFF,
    output reg LINK_RATE_TEN,
    output reg LINK_RATE_HUNDRED,
    output reg LINK_RATE_THOUSAND,
    output reg FORCED_SETUP_MODE,
    output reg WAKE_LAN_ENABLE,
    output reg [15:0] SUBSYS_VENDOR_IDENT,
    output reg [15:0] SUBSYS_IDENT,
    output reg [31:0] BASE_ADDR,
    output reg AUTO_POWER_SAVING,
    output reg [1:0] INDICATOR_MODE,
    output reg LOAD_DONE,
    // status lamps, active low
    output reg LAMP_TEN_N,
    output reg LAMP_HUNDRED_N,
    output reg LAMP_THOUSAND_N,
    output reg LAMP_DUPLEX_N,
    output reg LAMP_RECEIVE_N,
    output reg LAMP_TRANSMIT_N
);
    localparam ST_IDLE = 2'h0;
    localparam ST_FETCH = 2'h1;
    localparam ST_GAP = 2'h2;
    localparam ST_DONE = 2'h3;

    reg [1:0] state;
    reg load_pending;
    reg [6:0] sync1;
    reg [6:0] sync2;
    reg [6:0] sync3;
    reg [6:0] phy;
    wire blink_fast;
    wire blink_slow;
    reg next_ten;
    reg next_hundred;
    reg next_thousand;
    reg next_duplex;
    reg next_receive;
    reg next_transmit;

    // phy field positions inside the synchronised vector
    wire link_up = phy[0];
    wire [1:0] rate = phy[2:1];
    wire full_dup = phy[3];
    wire coll = phy[4];
    wire rx_act = phy[5];
    wire tx_act = phy[6];

    function at_rate;
        input up;
        input [1:0] cur;
        input [1:0] want;
        begin
            at_rate = up && (cur == want);
        end
    endfunction

    // reload strobe: a write of one to bit 0 of the load register
    function reload_hit;
        input wr;
        input [7:0] addr;
        input wdat0;
        begin
            reload_hit = wr && addr == `EELD_REG_LOAD && wdat0;
        end
    endfunction

    eeld_blinker #(
        .FAST_HALF(FAST_HALF),
        .SLOW_HALF(SLOW_HALF)
    ) u_blink (
        .clk(CORE_CLK),
        .rst(RESET),
        .blink_fast(blink_fast),
        .blink_slow(blink_slow)
    );

    // three stage sync; a bit moves only once stages two and three agree
    always @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            sync1 <= 7'h0;
            sync2 <= 7'h0;
            sync3 <= 7'h0;
            phy <= 7'h0;
        end else begin
            sync1 <= {TX_ACTIVE, RX_ACTIVE, COLLISION, FULL_DUPLEX, LINK_RATE, LINK_UP};
            sync2 <= sync1;
            sync3 <= sync2;
            phy <= (sync2 & sync3) | (phy & (sync2 | sync3));
        end
    end

    // word fetch sequencer
    always @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            state <= ST_IDLE;
            load_pending <= 1'b1;
            EE_REQ <= 1'b0;
            EE_ADDR <= 6'h0;
            LOAD_DONE <= 1'b0;
            EXPANSION_ROM_OFF <= 1'b0;
            LINK_RATE_TEN <= 1'b0;
            LINK_RATE_HUNDRED <= 1'b0;
            LINK_RATE_THOUSAND <= 1'b0;
            FORCED_SETUP_MODE <= 1'b0;
            WAKE_LAN_ENABLE <= 1'b0;
            SUBSYS_VENDOR_IDENT <= 16'h0;
            SUBSYS_IDENT <= 16'h0;
            BASE_ADDR <= 32'h0;
            AUTO_POWER_SAVING <= `EELD_RST_APS;
            INDICATOR_MODE <= `EELD_RST_MODE;
        end else begin
            // a reload request during a load is kept and served afterwards
            if (reload_hit(WR, ADDR, WDATA[0])) begin
                load_pending <= 1'b1;
            end
            if (WR && ADDR == `EELD_REG_INDICATOR) begin
                INDICATOR_MODE <= WDATA[1:0];
            end
            case (state)
                ST_IDLE, ST_DONE: begin
                    if (load_pending) begin
                        load_pending <= reload_hit(WR, ADDR, WDATA[0]);
                        LOAD_DONE <= 1'b0;
                        EE_ADDR <= `EELD_WORD_CHIP_CTRL;
                        EE_REQ <= 1'b1;
                        state <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    if (EE_VALID) begin
                        EE_REQ <= 1'b0;
                        if (EE_ADDR == `EELD_WORD_CHIP_CTRL) begin
                            // bits 2 and 3 are not looked at
                            EXPANSION_ROM_OFF <= EE_DATA[`EELD_CC_ROM_OFF];
                            LINK_RATE_TEN <= EE_DATA[`EELD_CC_RATE_TEN];
                            LINK_RATE_HUNDRED <= EE_DATA[`EELD_CC_RATE_HUNDRED];
                            LINK_RATE_THOUSAND <= EE_DATA[`EELD_CC_RATE_THOUSAND];
                            FORCED_SETUP_MODE <= EE_DATA[`EELD_CC_FORCED];
                            WAKE_LAN_ENABLE <= EE_DATA[`EELD_CC_WAKE_POL];
                        end else if (EE_ADDR == `EELD_WORD_SUB_VENDOR) begin
                            SUBSYS_VENDOR_IDENT <= EE_DATA;
                        end else if (EE_ADDR == `EELD_WORD_SUB_IDENT) begin
                            SUBSYS_IDENT <= EE_DATA;
                        end else if (EE_ADDR == `EELD_WORD_BASE_LO) begin
                            AUTO_POWER_SAVING <= EE_DATA[`EELD_BL_APS];
                            if (FORCED_SETUP_MODE) begin
                                BASE_ADDR[15:8] <= EE_DATA[15:8];
                            end
                        end else if (EE_ADDR == `EELD_WORD_BASE_HI) begin
                            if (FORCED_SETUP_MODE) begin
                                BASE_ADDR[31:16] <= EE_DATA;
                            end
                        end else begin
                            INDICATOR_MODE <= EE_DATA[`EELD_LED_MODE_MSB:`EELD_LED_MODE_LSB];
                        end
                        if (EE_ADDR == `EELD_WORD_LED) begin
                            LOAD_DONE <= 1'b1;
                            state <= ST_DONE;
                        end else begin
                            state <= ST_GAP;
                        end
                    end
                end
                default: begin
                    // one idle cycle between words keeps each request distinct
                    EE_ADDR <= EE_ADDR + 6'h1;
                    EE_REQ <= 1'b1;
                    state <= ST_FETCH;
                end
            endcase
        end
    end

    // lamp decode, lit level is 1 here
    always @* begin
        next_ten = at_rate(link_up, rate, `EELD_RATE_10);
        next_hundred = at_rate(link_up, rate, `EELD_RATE_100);
        next_thousand = at_rate(link_up, rate, `EELD_RATE_1000);
        next_duplex = coll ? blink_fast : full_dup;
        next_receive = rx_act;
        next_transmit = tx_act;
        case (INDICATOR_MODE)
            2'h0: begin
                next_hundred = at_rate(link_up, rate, `EELD_RATE_1000)
                    || at_rate(link_up, rate, `EELD_RATE_100);
                next_ten = at_rate(link_up, rate, `EELD_RATE_1000)
                    || at_rate(link_up, rate, `EELD_RATE_10);
                next_thousand = link_up;
                next_duplex = full_dup;
                next_receive = link_up && (rx_act ? blink_fast : 1'b1);
                next_transmit = link_up && ((rx_act || tx_act) ? blink_fast : 1'b1);
            end
            2'h2: begin
                // dark at 10 and 1000, slow blink at 100
                next_ten = at_rate(link_up, rate, `EELD_RATE_100) && blink_slow;
            end
            default: begin
                // modes 1 and 3 share the per-rate decode above
            end
        endcase
    end

    always @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            LAMP_TEN_N <= 1'b1;
            LAMP_HUNDRED_N <= 1'b1;
            LAMP_THOUSAND_N <= 1'b1;
            LAMP_DUPLEX_N <= 1'b1;
            LAMP_RECEIVE_N <= 1'b1;
            LAMP_TRANSMIT_N <= 1'b1;
        end else begin
            LAMP_TEN_N <= ~next_ten;
            LAMP_HUNDRED_N <= ~next_hundred;
            LAMP_THOUSAND_N <= ~next_thousand;
            LAMP_DUPLEX_N <= ~next_duplex;
            LAMP_RECEIVE_N <= ~next_receive;
            LAMP_TRANSMIT_N <= ~next_transmit;
        end
    end

    // register read port, data one cycle after the strobe
    always @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            RDATA <= 32'h0;
        end else if (RD) begin
            if (ADDR == `EELD_REG_CHIP_CTRL) begin
                RDATA <= {23'h0, FORCED_SETUP_MODE, 1'b0, LINK_RATE_THOUSAND,
                    LINK_RATE_HUNDRED, LINK_RATE_TEN, 3'h0, EXPANSION_ROM_OFF};
            end else if (ADDR == `EELD_REG_WAKE) begin
                RDATA <= {31'h0, WAKE_LAN_ENABLE};
            end else if (ADDR == `EELD_REG_SUB_VENDOR) begin
                RDATA <= {16'h0, SUBSYS_VENDOR_IDENT};
            end else if (ADDR == `EELD_REG_SUB_IDENT) begin
                RDATA <= {16'h0, SUBSYS_IDENT};
            end else if (ADDR == `EELD_REG_BASE) begin
                RDATA <= BASE_ADDR;
            end else if (ADDR == `EELD_REG_INDICATOR) begin
                RDATA <= {27'h0, AUTO_POWER_SAVING, 2'h0, INDICATOR_MODE};
            end else if (ADDR == `EELD_REG_LOAD) begin
                RDATA <= {29'h0, load_pending, LOAD_DONE, state != ST_IDLE && state != ST_DONE};
            end else if (ADDR == `EELD_REG_LINK) begin
                RDATA <= {25'h0, phy};
            end else begin
                RDATA <= 32'h0;
            end
        end else begin
            RDATA <= 32'h0;
        end
    end
endmodule // eeld_config_loader
`default_nettype wire

// [design/eeld_defines.vh]
// constants for the configuration word loader and lamp decoder
`ifndef EELD_DEFINES_VH
`define EELD_DEFINES_VH
// configuration word offsets in the serial store
`define EELD_WORD_CHIP_CTRL 6'h01
`define EELD_WORD_SUB_VENDOR 6'h02
`define EELD_WORD_SUB_IDENT 6'h03
`define EELD_WORD_BASE_LO 6'h04
`define EELD_WORD_BASE_HI 6'h05
`define EELD_WORD_LED 6'h06
// chip control word fields
`define EELD_CC_ROM_OFF 0
`define EELD_CC_RATE_TEN 4
`define EELD_CC_RATE_HUNDRED 5
`define EELD_CC_RATE_THOUSAND 6
`define EELD_CC_FORCED 8
`define EELD_CC_WAKE_POL 15
// lower base word fields
`define EELD_BL_APS 0
// led word field
`define EELD_LED_MODE_MSB 1
`define EELD_LED_MODE_LSB 0
// register offsets (byte addresses)
`define EELD_REG_CHIP_CTRL 8'h00
`define EELD_REG_WAKE 8'h04
`define EELD_REG_SUB_VENDOR 8'h08
`define EELD_REG_SUB_IDENT 8'h0c
`define EELD_REG_BASE 8'h10
`define EELD_REG_INDICATOR 8'h14
`define EELD_REG_LOAD 8'h18
`define EELD_REG_LINK 8'h1c
// reset values
`define EELD_RST_MODE 2'h1
`define EELD_RST_APS 1'b1
// link rate codes on the phy status input
`define EELD_RATE_10 2'h0
`define EELD_RATE_100 2'h1
`define EELD_RATE_1000 2'h2
// blink timing
`define EELD_CLK_PERIOD_NS 10
`define EELD_FAST_HALF_NS 20000000
`define EELD_SLOW_HALF_NS 80000000
`define EELD_FAST_HALF_CYC (`EELD_FAST_HALF_NS / `EELD_CLK_PERIOD_NS)
`define EELD_SLOW_HALF_CYC (`EELD_SLOW_HALF_NS / `EELD_CLK_PERIOD_NS)
`endif

// [verification/eeld_config_loader_sva.sv]
// assertion checker for the configuration loader ports
`timescale 1ns/1ps
`default_nettype none
module eeld_config_loader_sva (
    // clock and reset
    input wire CORE_CLK,
    input wire RESET,
    // word port
    input wire EE_REQ,
    input wire [5:0] EE_ADDR,
    input wire [15:0] EE_DATA,
    input wire EE_VALID,
    input wire LINK_UP,
    // loaded configuration
    input wire EXPANSION_ROM_OFF,
    input wire LINK_RATE_TEN,
    input wire LINK_RATE_HUNDRED,
    input wire LINK_RATE_THOUSAND,
    input wire FORCED_SETUP_MODE,
    input wire WAKE_LAN_ENABLE,
    input wire [15:0] SUBSYS_VENDOR_IDENT,
    input wire [15:0] SUBSYS_IDENT,
    input wire [31:0] BASE_ADDR,
    input wire AUTO_POWER_SAVING,
    input wire [1:0] INDICATOR_MODE,
    input wire LOAD_DONE,
    // lamps
    input wire LAMP_TEN_N,
    input wire LAMP_HUNDRED_N,
    input wire LAMP_THOUSAND_N
);
    // one-hot of the word offset taken this cycle
    wire [7:0] got = {7'h00, EE_REQ & EE_VALID} << EE_ADDR;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RESET);
    ctrl_bits_a: assert property (got[1] |=>
        {FORCED_SETUP_MODE, LINK_RATE_THOUSAND, LINK_RATE_HUNDRED, LINK_RATE_TEN,
        EXPANSION_ROM_OFF} == $past({EE_DATA[8], EE_DATA[6:4], EE_DATA[0]}))
        else $error("chip control bits wrong");
    wake_enable_a: assert property (got[1] |=> WAKE_LAN_ENABLE == $past(EE_DATA[15]))
        else $error("wake enable wrong");
    vendor_load_a: assert property (got[2] |=> SUBSYS_VENDOR_IDENT == $past(EE_DATA))
        else $error("vendor ident wrong");
    ident_load_a: assert property (got[3] |=> SUBSYS_IDENT == $past(EE_DATA))
        else $error("subsystem ident wrong");
    power_save_a: assert property (got[4] |=> AUTO_POWER_SAVING == $past(EE_DATA[0]))
        else $error("power saving wrong");
    base_low_a: assert property (got[4] && FORCED_SETUP_MODE |=>
        BASE_ADDR[15:8] == $past(EE_DATA[15:8]))
        else $error("base low byte wrong");
    base_high_a: assert property (got[5] && FORCED_SETUP_MODE |=>
        BASE_ADDR[31:16] == $past(EE_DATA))
        else $error("base high word wrong");
    mode_load_a: assert property (got[6] |=> INDICATOR_MODE == $past(EE_DATA[1:0]))
        else $error("indicator mode wrong");
    word_order_a: assert property (EE_REQ && EE_VALID && EE_ADDR < 6'h06 |=>
        !EE_REQ ##1 (EE_REQ && EE_ADDR == $past(EE_ADDR, 2) + 6'h01)) else $error("word order wrong");
    load_done_a: assert property (got[6] |=> LOAD_DONE && !EE_REQ)
        else $error("load not done");
    lamps_dark_a: assert property (!LINK_UP [*8] |->
        LAMP_TEN_N && LAMP_HUNDRED_N && LAMP_THOUSAND_N)
        else $error("rate lamp lit without link");
    cover property (got[6]);
    cover property (got[4] && FORCED_SETUP_MODE);
    cover property (!LINK_UP [*8]);
endmodule // eeld_config_loader_sva
bind eeld_config_loader eeld_config_loader_sva u_sva (.CORE_CLK(CORE_CLK), .RESET(RESET),
    .EE_REQ(EE_REQ), .EE_ADDR(EE_ADDR), .EE_DATA(EE_DATA), .EE_VALID(EE_VALID), .LINK_UP(LINK_UP),
    .EXPANSION_ROM_OFF(EXPANSION_ROM_OFF), .LINK_RATE_TEN(LINK_RATE_TEN),
    .LINK_RATE_HUNDRED(LINK_RATE_HUNDRED), .LINK_RATE_THOUSAND(LINK_RATE_THOUSAND),
    .FORCED_SETUP_MODE(FORCED_SETUP_MODE), .WAKE_LAN_ENABLE(WAKE_LAN_ENABLE),
    .SUBSYS_VENDOR_IDENT(SUBSYS_VENDOR_IDENT), .SUBSYS_IDENT(SUBSYS_IDENT), .BASE_ADDR(BASE_ADDR),
    .AUTO_POWER_SAVING(AUTO_POWER_SAVING), .INDICATOR_MODE(INDICATOR_MODE), .LOAD_DONE(LOAD_DONE),
    .LAMP_TEN_N(LAMP_TEN_N), .LAMP_HUNDRED_N(LAMP_HUNDRED_N), .LAMP_THOUSAND_N(LAMP_THOUSAND_N));
`default_nettype wire

// [verification/eeld_config_loader_test.sv]
// self-checking bench for the configuration loader and lamp decoder
`timescale 1ns/1ps
`default_nettype none
`include "eeld_defines.vh"
module eeld_config_loader_test;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic slow = 1'b0;
    logic link_up = 1'b0;
    logic full_dup = 1'b0;
    logic coll = 1'b0;
    logic rx_act = 1'b0;
    logic tx_act = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [1:0] link_rate = 2'h0;
    wire [31:0] rdata, base;
    wire [15:0] ee_data, vend, ident;
    wire [5:0] ee_addr;
    wire [1:0] mode;
    wire ee_req, ee_valid, rom_off, r10, r100, r1000, forced, wake, auto_power_saving, done;
    wire l10, l100, l1000, ldup, lrx, ltx;
    wire [3:0] lv = {l1000, l100, l10, ldup};
    int n_mismatch = 0;
    int comparisons = 0;
    always #5 clk = ~clk;
    // short blink periods keep the run brief
    eeld_config_loader #(.FAST_HALF(4), .SLOW_HALF(16)) u_dut (
        .CORE_CLK(clk), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .EE_REQ(ee_req), .EE_ADDR(ee_addr), .EE_DATA(ee_data),
        .EE_VALID(ee_valid), .LINK_UP(link_up), .LINK_RATE(link_rate),
        .FULL_DUPLEX(full_dup), .COLLISION(coll), .RX_ACTIVE(rx_act), .TX_ACTIVE(tx_act),
        .EXPANSION_ROM_OFF(rom_off), .LINK_RATE_TEN(r10), .LINK_RATE_HUNDRED(r100),
        .LINK_RATE_THOUSAND(r1000), .FORCED_SETUP_MODE(forced), .WAKE_LAN_ENABLE(wake),
        .SUBSYS_VENDOR_IDENT(vend), .SUBSYS_IDENT(ident), .BASE_ADDR(base),
        .AUTO_POWER_SAVING(auto_power_saving), .INDICATOR_MODE(mode), .LOAD_DONE(done),
        .LAMP_TEN_N(l10), .LAMP_HUNDRED_N(l100), .LAMP_THOUSAND_N(l1000),
        .LAMP_DUPLEX_N(ldup), .LAMP_RECEIVE_N(lrx), .LAMP_TRANSMIT_N(ltx));
    eeld_store_model u_store (.clk(clk), .rst(reset), .req(ee_req), .addr(ee_addr),
        .slow(slow), .valid(ee_valid), .data(ee_data));
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task automatic load_words(input logic [95:0] w);
        for (int i = 1; i <= 6; i++) u_store.mem[i] = w[96 - 16 * i +: 16];
    endtask
    task automatic wait_load;
        int i;
        i = 0;
        while (!(ee_valid === 1'b1 && ee_addr === 6'h06) && i < 500) begin
            @(posedge clk);
            #1 i++;
        end
        repeat (2) @(posedge clk);
        #1 chk(done, 1'b1);
    endtask
    // lamps settle a few cycles after the phy pins move, through the synchronisers
    task automatic lamp_case(input logic up, input logic [1:0] rate, input logic dup,
        input logic [3:0] e);
        @(posedge clk);
        link_up <= up;
        link_rate <= rate;
        full_dup <= dup;
        repeat (10) @(posedge clk);
        #1 chk(lv, e);
    endtask
    task automatic toggles(input int idx, input int n);
        logic s0, s1;
        s0 = 1'b0;
        s1 = 1'b0;
        repeat (n) begin
            @(posedge clk);
            #1 if (lv[idx] === 1'b1) s1 = 1'b1;
            else if (lv[idx] === 1'b0) s0 = 1'b1;
        end
        chk({s0, s1}, 2'b11);
    endtask
    task automatic conclude;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        n_mismatch++;
        conclude();
    end
    initial begin
        load_words({16'h8151, 16'h1a2b, 16'h3c4d, 16'h5e00, 16'h6f70, 16'h0000});
        repeat (11) @(posedge clk);
        #1 chk({auto_power_saving, mode, done}, 4'b1010);
        @(posedge clk);
        reset <= 1'b0;
        wait_load();
        chk({rom_off, r1000, r100, r10, forced, wake}, 6'b110111);
        chk({vend, ident}, 32'h1a2b3c4d);
        chk({base, auto_power_saving, mode}, {32'h6f705e00, 3'b000});
        rd_chk(`EELD_REG_CHIP_CTRL, 32'h00000151);
        rd_chk(`EELD_REG_WAKE, 32'h00000001);
        wr_reg(`EELD_REG_SUB_IDENT, 32'h0);
        rd_chk(`EELD_REG_SUB_IDENT, 32'h00003c4d);
        rd_chk(8'h40, 32'h0);
        rd_chk(`EELD_REG_BASE, 32'h6f705e00);
        rd_chk(`EELD_REG_LOAD, 32'h00000002);
        lamp_case(1'b1, `EELD_RATE_1000, 1'b1, 4'b0000);
        chk({lrx, ltx}, 2'b00);
        rd_chk(`EELD_REG_LINK, 32'h0000000d);
        lamp_case(1'b1, `EELD_RATE_100, 1'b0, 4'b0011);
        lamp_case(1'b1, `EELD_RATE_10, 1'b1, 4'b0100);
        lamp_case(1'b0, `EELD_RATE_10, 1'b0, 4'b1111);
        chk({lrx, ltx}, 2'b11);
        wr_reg(`EELD_REG_INDICATOR, 32'h1);
        rd_chk(`EELD_REG_INDICATOR, 32'h1);
        @(posedge clk);
        tx_act <= 1'b1;
        lamp_case(1'b1, `EELD_RATE_1000, 1'b1, 4'b0110);
        chk({lrx, ltx}, 2'b10);
        lamp_case(1'b1, `EELD_RATE_100, 1'b0, 4'b1011);
        lamp_case(1'b1, `EELD_RATE_10, 1'b1, 4'b1100);
        @(posedge clk);
        coll <= 1'b1;
        toggles(0, 40);
        load_words({16'h0020, 16'h0102, 16'h0304, 16'h0001, 16'hffff, 16'h0002});
        @(posedge clk);
        coll <= 1'b0;
        slow <= 1'b1;
        wr_reg(`EELD_REG_LOAD, 32'h1);
        wait_load();
        chk({rom_off, r1000, r100, r10, forced, wake}, 6'b001000);
        chk({vend, ident, auto_power_saving, mode}, {32'h01020304, 3'b110});
        chk(base, 32'h6f705e00);
        lamp_case(1'b1, `EELD_RATE_10, 1'b0, 4'b1111);
        @(posedge clk);
        link_rate <= `EELD_RATE_100;
        toggles(1, 80);
        conclude();
    end
endmodule // eeld_config_loader_test
`default_nettype wire

// [verification/eeld_store_model.sv]
// partner model: serial store answering word requests
`timescale 1ns/1ps
`default_nettype none
module eeld_store_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // word port
    input wire logic req,
    input wire logic [5:0] addr,
    input wire logic slow,
    output logic valid,
    output logic [15:0] data
);
    logic [15:0] mem [0:63];
    logic [1:0] wait_cnt;
    // data churns between answers so a stale word never passes for a fresh one
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            valid <= 1'b0;
            data <= 16'h0000;
            wait_cnt <= 2'h0;
        end else if (req && !valid && (!slow || wait_cnt == 2'h3)) begin
            valid <= 1'b1;
            data <= mem[addr];
            wait_cnt <= 2'h0;
        end else begin
            valid <= 1'b0;
            data <= ~data;
            wait_cnt <= (req && !valid) ? wait_cnt + 2'h1 : 2'h0;
        end
    end
endmodule // eeld_store_model
`default_nettype wire
